// file: core/fpmc_pkg.sv
// Package for the front-panel mode controller: timing, lamp indices, types.
// Assumes a 125 MHz system clock.
package fpmc_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int DEBOUNCE_MS = 20;
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int SEL_HOLD_MS = 1000;
	localparam int SEL_HOLD_CYC = CLK_HZ / 1000 * SEL_HOLD_MS + 1;
	localparam int POL_HOLD_MS = 1500;
	localparam int POL_HOLD_CYC = CLK_HZ / 1000 * POL_HOLD_MS;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int SLOW_HALF_MS = 1000;
	localparam int SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
	localparam int SCAN_STEP_MS = 500;
	localparam int SCAN_STEP_CYC = CLK_HZ / 1000 * SCAN_STEP_MS;
	localparam int NUM_INPUTS = 3;
	localparam int SAMPLE_W = 24;
	localparam logic [1:0] IN_LAST = 2'h2;
	localparam logic [1:0] IN_FIRST = 2'h0;
	localparam logic [1:0] RATE_441 = 2'h0;
	localparam logic [1:0] RATE_48 = 2'h1;
	localparam logic [1:0] RATE_882 = 2'h2;
	localparam logic [1:0] RATE_96 = 2'h3;
	localparam logic [3:0] LAMPS_UPPER = 4'h3;
	localparam logic [3:0] LAMPS_LOWER = 4'hc;
	localparam logic [3:0] LAMP_ONE = 4'h1;
	localparam logic [2:0] INLAMP_ONE = 3'h1;

	typedef enum logic [2:0] {ST_MUTE, ST_WARM, ST_CAL, ST_ACQ, ST_RUN} fpmc_state_e;

	typedef struct packed {
		logic scan_mode;
		logic crystal_mode;
	} fpmc_nv_s;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} fpmc_audio_s;
endpackage

// file: core/fpmc_top.sv
// Front-panel supervisory controller: buttons, lamps, start-up, mute, polarity.
// Assumes buttons are raw active-high pins; saved settings come from external storage.
// Functional notes
// - Input-select press advances selection; input lamps always show chosen input.
// - Input-select hold over one second toggles scan and manual mode.
// - Scan/manual mode is saved to storage and restored at power-up.
// - Scan mode press moves to next input with valid signal.
// - Manual mode press moves to next position regardless of signal.
// - Scan mode is the default when no saved setting exists.
// - Selector cycles three inputs: two AES/EBU and one SPDIF.
// - Power-up starts muted before any other step.
// - During warm-up flash the 44.1 and 48 lamps.
// - At temperature, calibrate and flash 88.2 and 96 lamps until done.
// - After calibration in scan mode, find first active input and play.
// - Light the one lamp matching the measured rate of the input.
// - Scan mode with no active input steps inputs forever, updating lamps.
// - Polarity press toggles inversion; invert lamp steady while inverted.
// - Loop clock mode is default; rate lamp blinks slowly.
// - Fixed-crystal mode keeps the rate lamp steadily lit.
// - Clock mode is saved to storage and restored at power-up.
`timescale 1ns/100ps
`default_nettype none
module fpmc_top
	import fpmc_pkg::*;
#(
	parameter int DEB_CYC = DEBOUNCE_CYC,
	parameter int SHOLD_CYC = SEL_HOLD_CYC,
	parameter int PHOLD_CYC = POL_HOLD_CYC,
	parameter int FLASH_CYC = FLASH_HALF_CYC,
	parameter int SLOW_CYC = SLOW_HALF_CYC,
	parameter int STEP_CYC = SCAN_STEP_CYC
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic SRST_I,
	// Buttons (raw pins)
	input wire logic SEL_BTN_I,
	input wire logic POL_BTN_I,
	// Saved settings
	input wire logic NV_VALID_I,
	input wire fpmc_nv_s NV_DATA_I,
	output fpmc_nv_s NV_DATA_O,
	output logic NV_WR_O,
	// Oven, calibration, receivers
	input wire logic OVEN_READY_I,
	output logic CAL_START_O,
	input wire logic CAL_DONE_I,
	input wire logic [NUM_INPUTS-1:0] SIG_VALID_I,
	input wire logic [1:0] RATE_I,
	// Audio
	input wire fpmc_audio_s AUDIO_I,
	output fpmc_audio_s AUDIO_O,
	output logic MUTE_O,
	// Lamps and selection
	output logic [1:0] INPUT_SEL_O,
	output logic [NUM_INPUTS-1:0] INPUT_LAMP_O,
	output logic [3:0] RATE_LAMP_O,
	output logic INVERT_LAMP_O,
	output logic SCAN_MODE_O,
	output logic CRYSTAL_MODE_O
);
	logic [1:0] btn_s1_q, btn_s2_q, btn_db_q;
	logic [31:0] deb_cnt_q [2];
	logic [31:0] hold_cnt_q [2];
	logic [1:0] held_q;
	logic [1:0] short_q, long_q;
	logic [NUM_INPUTS-1:0] vld_s1_q, vld_s2_q;
	logic oven_s1_q, oven_s2_q, cal_s1_q, cal_s2_q;
	logic [31:0] hold_max [2];
	assign hold_max[0] = SHOLD_CYC;
	assign hold_max[1] = PHOLD_CYC;

	// Two-stage syncs, debounce and press timing per button
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_btn
			logic raw;
			assign raw = (g == 0) ? SEL_BTN_I : POL_BTN_I;
			always_ff @(posedge MCLK_I) begin
				if (SRST_I) begin
					btn_s1_q[g] <= 1'b0;
					btn_s2_q[g] <= 1'b0;
				end else begin
					btn_s1_q[g] <= raw;
					btn_s2_q[g] <= btn_s1_q[g];
				end
			end
			always_ff @(posedge MCLK_I) begin
				if (SRST_I) begin
					btn_db_q[g] <= 1'b0;
					deb_cnt_q[g] <= '0;
				end else if (btn_s2_q[g] == btn_db_q[g]) begin
					deb_cnt_q[g] <= '0;
				end else if (deb_cnt_q[g] >= 32'(DEB_CYC - 1)) begin
					btn_db_q[g] <= btn_s2_q[g];
					deb_cnt_q[g] <= '0;
				end else begin
					deb_cnt_q[g] <= deb_cnt_q[g] + 32'h1;
				end
			end
			// Long action fires once at threshold; release after it is no short press
			always_ff @(posedge MCLK_I) begin
				if (SRST_I) begin
					hold_cnt_q[g] <= '0;
					held_q[g] <= 1'b0;
					short_q[g] <= 1'b0;
					long_q[g] <= 1'b0;
				end else begin
					short_q[g] <= 1'b0;
					long_q[g] <= 1'b0;
					if (btn_db_q[g]) begin
						if (!held_q[g] && hold_cnt_q[g] >= hold_max[g] - 32'h1) begin
							held_q[g] <= 1'b1;
							long_q[g] <= 1'b1;
						end else if (!held_q[g]) begin
							hold_cnt_q[g] <= hold_cnt_q[g] + 32'h1;
						end
					end else begin
						if (hold_cnt_q[g] != '0 && !held_q[g])
							short_q[g] <= 1'b1;
						hold_cnt_q[g] <= '0;
						held_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			vld_s1_q <= '0;
			vld_s2_q <= '0;
			oven_s1_q <= 1'b0;
			oven_s2_q <= 1'b0;
			cal_s1_q <= 1'b0;
			cal_s2_q <= 1'b0;
		end else begin
			vld_s1_q <= SIG_VALID_I;
			vld_s2_q <= vld_s1_q;
			oven_s1_q <= OVEN_READY_I;
			oven_s2_q <= oven_s1_q;
			cal_s1_q <= CAL_DONE_I;
			cal_s2_q <= cal_s1_q;
		end
	end

	// Start-up sequence
	fpmc_state_e state_q;
	logic nv_loaded_q;
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			state_q <= ST_MUTE;
			CAL_START_O <= 1'b0;
		end else begin
			CAL_START_O <= 1'b0;
			case (state_q)
				ST_MUTE: state_q <= ST_WARM;
				ST_WARM: if (oven_s2_q) begin
					state_q <= ST_CAL;
					CAL_START_O <= 1'b1;
				end
				ST_CAL: if (cal_s2_q) state_q <= ST_ACQ;
				ST_ACQ: if (vld_s2_q[INPUT_SEL_O]) state_q <= ST_RUN;
				ST_RUN: if (!vld_s2_q[INPUT_SEL_O]) state_q <= ST_ACQ;
				default: state_q <= ST_MUTE;
			endcase
		end
	end

	// Saved modes: load once after reset, write back on every change
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			SCAN_MODE_O <= 1'b1;
			CRYSTAL_MODE_O <= 1'b0;
			nv_loaded_q <= 1'b0;
			NV_WR_O <= 1'b0;
			NV_DATA_O <= '0;
		end else begin
			NV_WR_O <= 1'b0;
			if (!nv_loaded_q) begin
				nv_loaded_q <= 1'b1;
				if (NV_VALID_I) begin
					SCAN_MODE_O <= NV_DATA_I.scan_mode;
					CRYSTAL_MODE_O <= NV_DATA_I.crystal_mode;
				end
			end else if (long_q[0] || long_q[1]) begin
				SCAN_MODE_O <= SCAN_MODE_O ^ long_q[0];
				CRYSTAL_MODE_O <= CRYSTAL_MODE_O ^ long_q[1];
				NV_DATA_O.scan_mode <= SCAN_MODE_O ^ long_q[0];
				NV_DATA_O.crystal_mode <= CRYSTAL_MODE_O ^ long_q[1];
				NV_WR_O <= 1'b1;
			end
		end
	end

	// Input selection
	logic [1:0] nxt1, nxt2, nxt3, nxt_valid;
	logic [31:0] step_cnt_q;
	logic step_tick;
	always_comb begin
		nxt1 = (INPUT_SEL_O == IN_LAST) ? IN_FIRST : INPUT_SEL_O + 2'h1;
		nxt2 = (nxt1 == IN_LAST) ? IN_FIRST : nxt1 + 2'h1;
		nxt3 = INPUT_SEL_O;
		if (vld_s2_q[nxt1]) nxt_valid = nxt1;
		else if (vld_s2_q[nxt2]) nxt_valid = nxt2;
		else nxt_valid = nxt3;
	end
	assign step_tick = (step_cnt_q >= 32'(STEP_CYC - 1));
	always_ff @(posedge MCLK_I) begin
		if (SRST_I || state_q != ST_ACQ || !SCAN_MODE_O || vld_s2_q[INPUT_SEL_O])
			step_cnt_q <= '0;
		else if (step_tick)
			step_cnt_q <= '0;
		else
			step_cnt_q <= step_cnt_q + 32'h1;
	end
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			INPUT_SEL_O <= IN_FIRST;
		end else if (short_q[0]) begin
			INPUT_SEL_O <= SCAN_MODE_O ? nxt_valid : nxt1;
		end else if (state_q == ST_ACQ && SCAN_MODE_O && step_tick) begin
			INPUT_SEL_O <= nxt1;
		end
	end
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) INPUT_LAMP_O <= INLAMP_ONE;
		else INPUT_LAMP_O <= INLAMP_ONE << INPUT_SEL_O;
	end

	// Blink timers
	logic [31:0] fl_cnt_q, sl_cnt_q;
	logic fl_q, sl_q;
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			fl_cnt_q <= '0;
			fl_q <= 1'b0;
		end else if (fl_cnt_q >= 32'(FLASH_CYC - 1)) begin
			fl_cnt_q <= '0;
			fl_q <= ~fl_q;
		end else begin
			fl_cnt_q <= fl_cnt_q + 32'h1;
		end
	end
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			sl_cnt_q <= '0;
			sl_q <= 1'b0;
		end else if (sl_cnt_q >= 32'(SLOW_CYC - 1)) begin
			sl_cnt_q <= '0;
			sl_q <= ~sl_q;
		end else begin
			sl_cnt_q <= sl_cnt_q + 32'h1;
		end
	end

	// Rate lamps
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			RATE_LAMP_O <= '0;
		end else begin
			case (state_q)
				ST_WARM: RATE_LAMP_O <= fl_q ? LAMPS_UPPER : 4'h0;
				ST_CAL: RATE_LAMP_O <= fl_q ? LAMPS_LOWER : 4'h0;
				ST_RUN: RATE_LAMP_O <= (CRYSTAL_MODE_O || sl_q) ?
					(LAMP_ONE << RATE_I) : 4'h0;
				default: RATE_LAMP_O <= 4'h0;
			endcase
		end
	end

	// Polarity, mute and audio path
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) INVERT_LAMP_O <= 1'b0;
		else if (short_q[1]) INVERT_LAMP_O <= ~INVERT_LAMP_O;
	end
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			MUTE_O <= 1'b1;
			AUDIO_O <= '0;
		end else begin
			MUTE_O <= (state_q != ST_RUN);
			if (state_q != ST_RUN)
				AUDIO_O <= '0;
			else if (INVERT_LAMP_O) begin
				AUDIO_O.left <= -AUDIO_I.left;
				AUDIO_O.right <= -AUDIO_I.right;
			end else
				AUDIO_O <= AUDIO_I;
		end
	end

	// Lamp checks skip the entry cycle of a state, which still shows the prior lamp
	sequence s_warm_held;
		state_q == ST_WARM ##1 state_q == ST_WARM;
	endsequence
	sequence s_cal_held;
		state_q == ST_CAL ##1 state_q == ST_CAL;
	endsequence
	a_mute_reset: assert property (@(posedge MCLK_I) $rose(SRST_I) |=> MUTE_O)
		else $error("not muted after reset");
	a_mute_run: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		state_q != ST_RUN |=> MUTE_O)
		else $error("unmuted before run");
	a_mute_audio: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		MUTE_O |-> AUDIO_O == '0)
		else $error("audio passed while muted");
	a_pol_toggle: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		short_q[1] |=> INVERT_LAMP_O != $past(INVERT_LAMP_O))
		else $error("polarity not toggled");
	a_invert_steady: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		!short_q[1] |=> $stable(INVERT_LAMP_O))
		else $error("invert lamp changed without a press");
	a_sel_manual: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		short_q[0] && !SCAN_MODE_O |=> INPUT_SEL_O == $past(nxt1))
		else $error("manual step wrong");
	// A scan press never lands on an idle input; with none valid it stays put
	a_sel_scan: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		short_q[0] && SCAN_MODE_O |=> INPUT_SEL_O == $past(INPUT_SEL_O) ||
			(|($past(vld_s2_q) & (INLAMP_ONE << INPUT_SEL_O))))
		else $error("scan step landed on an idle input");
	a_no_both: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		!(short_q[0] && long_q[0]))
		else $error("short and long together");
	a_lamp_sel: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		##1 INPUT_LAMP_O == (INLAMP_ONE << $past(INPUT_SEL_O)))
		else $error("input lamp mismatch");
	a_warm_lamps: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		s_warm_held |-> (RATE_LAMP_O & LAMPS_LOWER) == 4'h0)
		else $error("lower lamps in warm-up");
	a_cal_lamps: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		s_cal_held |-> (RATE_LAMP_O & LAMPS_UPPER) == 4'h0)
		else $error("upper lamps in calibration");
	a_crystal_steady: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		state_q == ST_RUN && CRYSTAL_MODE_O |=> RATE_LAMP_O != 4'h0)
		else $error("crystal lamp not steady");
	// Every mode change is stored with both saved bits at once
	a_nv_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		nv_loaded_q && (long_q[0] || long_q[1]) |=>
			NV_WR_O && NV_DATA_O == {SCAN_MODE_O, CRYSTAL_MODE_O})
		else $error("mode change not written back");
endmodule // fpmc_top
`default_nettype wire

// file: verification/fpmc_panel.sv
// Front-panel partner: two raw push buttons with contact bounce.
// Assumes the bench clock; the bench calls push to operate a button.
`timescale 1ns/100ps
`default_nettype none
module fpmc_panel (
	// Clock
	input wire logic clk_i,
	// Button pins, high while pressed
	output logic sel_btn_o,
	output logic pol_btn_o
);
	initial begin
		sel_btn_o = 1'b0;
		pol_btn_o = 1'b0;
	end

	// Bounce at both contact edges, as real switches do
	task automatic push(input bit pol, input int hold);
		logic v;
		for (int i = 0; i < hold + 6; i++) begin
			@(posedge clk_i);
			#1;
			v = (i < 3) ? !i[0] : (i < hold) ? 1'b1 : (i < hold + 3) ? i[0] : 1'b0;
			if (pol) begin
				pol_btn_o = v;
			end else begin
				sel_btn_o = v;
			end
		end
	endtask
endmodule // fpmc_panel
`default_nettype wire

// file: verification/tb_front_panel_mode_control.sv
// Testbench for the front-panel mode controller: start-up, buttons, lamps.
// Assumes short timing parameters; buttons come from the panel model.
`timescale 1ns/100ps
`default_nettype none
module tb_front_panel_mode_control
	import fpmc_pkg::*;
;
	logic clk, rst, nv_valid, oven, cal_done, nv_wr, cal_start, mute, inv_o, scan_o, crys_o;
	logic sel_b, pol_b;
	logic [2:0] sig, lamp_o;
	logic [1:0] rate, sel_o;
	logic [3:0] lamp_r;
	fpmc_nv_s nv_i, nv_o;
	fpmc_audio_s aud_i, aud_o;
	int n_errors = 0;
	int n_tests = 0;
	int n_cal = 0;
	int n_wr = 0;
	int steps;
	logic [1:0] prev;
	// Row: polarity button, long hold, valid inputs, then sel, scan, invert, crystal
	typedef struct packed {logic pol; logic lng; logic [2:0] sig; logic [1:0] sel; logic [2:0] m;} fpmc_row_s;
	fpmc_row_s rows [9] = '{
		{1'b1, 1'b0, 3'h4, 2'h2, 3'h6}, {1'b1, 1'b1, 3'h4, 2'h2, 3'h7},
		{1'b1, 1'b0, 3'h4, 2'h2, 3'h5}, {1'b1, 1'b1, 3'h4, 2'h2, 3'h4},
		{1'b0, 1'b0, 3'h5, 2'h0, 3'h4}, {1'b0, 1'b0, 3'h5, 2'h2, 3'h4},
		{1'b0, 1'b1, 3'h7, 2'h2, 3'h0}, {1'b0, 1'b0, 3'h5, 2'h0, 3'h0},
		{1'b0, 1'b0, 3'h5, 2'h1, 3'h0}};

	fpmc_panel pan (.clk_i(clk), .sel_btn_o(sel_b), .pol_btn_o(pol_b));

	fpmc_top #(.DEB_CYC(8), .SHOLD_CYC(40), .PHOLD_CYC(60), .FLASH_CYC(10), .SLOW_CYC(20),
		.STEP_CYC(30)) dut (
		.MCLK_I(clk), .SRST_I(rst), .SEL_BTN_I(sel_b), .POL_BTN_I(pol_b),
		.NV_VALID_I(nv_valid), .NV_DATA_I(nv_i), .NV_DATA_O(nv_o), .NV_WR_O(nv_wr),
		.OVEN_READY_I(oven), .CAL_START_O(cal_start), .CAL_DONE_I(cal_done),
		.SIG_VALID_I(sig), .RATE_I(rate), .AUDIO_I(aud_i), .AUDIO_O(aud_o), .MUTE_O(mute),
		.INPUT_SEL_O(sel_o), .INPUT_LAMP_O(lamp_o), .RATE_LAMP_O(lamp_r),
		.INVERT_LAMP_O(inv_o), .SCAN_MODE_O(scan_o), .CRYSTAL_MODE_O(crys_o));

	initial begin
		clk = 1'b0;
		forever #4 clk = !clk;
	end

	always @(posedge clk) begin
		if (cal_start === 1'b1) n_cal++;
		if (nv_wr === 1'b1) n_wr++;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Lamp may only show pat or dark; a blinking lamp must show both
	task automatic watch(input int n, input logic [3:0] pat, input bit steady);
		int on, off, bad;
		on = 0;
		off = 0;
		bad = 0;
		repeat (n) begin
			cyc(1);
			if (lamp_r === pat) on++;
			else if (lamp_r === 4'h0) off++;
			else bad++;
		end
		chk({bad == 0, on > 0, off > 0}, {1'b1, 1'b1, !steady});
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict;
	end

	initial begin
		rst = 1'b1;
		nv_valid = 1'b0;
		nv_i = '0;
		oven = 1'b0;
		cal_done = 1'b0;
		sig = 3'h0;
		rate = 2'h3;
		aud_i = {24'h000064, 24'hfffff9};
		cyc(3);
		chk({mute, lamp_o, lamp_r, inv_o, scan_o, crys_o, sel_o}, {1'b1, 3'h1, 4'h0, 3'h2, 2'h0});
		cyc(1);
		rst = 1'b0;
		watch(25, 4'h3, 0);
		chk(mute, 1'b1);
		oven = 1'b1;
		cyc(4);
		watch(25, 4'hc, 0);
		chk(n_cal, 1);
		cal_done = 1'b1;
		cyc(4);
		steps = 0;
		prev = sel_o;
		repeat (100) begin
			cyc(1);
			if (sel_o !== prev) steps++;
			prev = sel_o;
		end
		chk({steps >= 2, mute}, 2'h3);
		sig = 3'h4;
		cyc(100);
		chk({sel_o, lamp_o, mute}, {2'h2, 3'h4, 1'b0});
		watch(45, 4'h8, 0);
		foreach (rows[k]) begin
			sig = rows[k].sig;
			// Crystal rows at the low rates, loop rows at the high ones
			rate = rows[k].m[0] ? 2'(k - 1) : {1'b1, k[0]};
			aud_i = {24'(k + 1), 24'hfffff9};
			pan.push(rows[k].pol, rows[k].lng ? 100 : 20);
			cyc(20);
			chk({sel_o, lamp_o, scan_o, inv_o, crys_o},
				{rows[k].sel, 3'h1 << rows[k].sel, rows[k].m});
			if (rows[k].lng) chk(nv_o, rows[k].m[2:1] & 2'h2 | {1'b0, rows[k].m[0]});
			if (sig[rows[k].sel]) begin
				chk({mute, aud_o}, {1'b0, rows[k].m[1] ?
					{-24'(k + 1), 24'h000007} : {24'(k + 1), 24'hfffff9}});
				watch(45, LAMP_ONE << rate, rows[k].m[0]);
			end
		end
		chk(n_wr, 3);
		rst = 1'b1;
		nv_valid = 1'b1;
		nv_i = 2'h1;
		cyc(2);
		rst = 1'b0;
		cyc(3);
		chk({scan_o, crys_o}, 2'h1);
		print_verdict;
	end
endmodule // tb_front_panel_mode_control
`default_nettype wire
